// *** rtl/sbi_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the break/idle transmitter
`ifndef SBI_REGS_SVH
`define SBI_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SBI_ADDR_CTRL       3'h0
`define SBI_ADDR_BAUD       3'h1
`define SBI_ADDR_DATA       3'h2
`define SBI_ADDR_STAT       3'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define SBI_CTRL_BRK_REQ    0
`define SBI_CTRL_TX_EN      1
`define SBI_CTRL_M          2
`define SBI_CTRL_T8         3
`define SBI_STAT_BUSY       0
`define SBI_STAT_EMPTY      1
`define SBI_STAT_BRK_PEND   2
`define SBI_STAT_IDLE_PEND  3
`define SBI_STAT_LINE       4
`define SBI_STAT_IN_BREAK   5

// ****************************************************************
// Reset values
// ****************************************************************
`define SBI_CTRL_RESET      8'h00
`define SBI_BAUD_RESET      8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SBI_REF_CLK_HZ      200000000
`define SBI_CORE_CLK_HZ     8000000
`define SBI_CORE_DIV        (`SBI_REF_CLK_HZ / `SBI_CORE_CLK_HZ)
`define SBI_BITS_SHORT      4'hA
`define SBI_BITS_LONG       4'hB
`define SBI_TEST_DIVISOR    8'hC9
`define SBI_TEST_PERIOD     15'h01A0

`endif

// *** rtl/sbi_pkg.sv ***
// Types shared by the break/idle transmitter modules
package sbi_pkg;

    typedef enum logic [4:0] {
        SBI_ST_IDLE     = 5'h01,
        SBI_ST_PREAMBLE = 5'h02,
        SBI_ST_BREAK    = 5'h04,
        SBI_ST_GAP      = 5'h08,
        SBI_ST_DATA     = 5'h10
    } sbi_state_t;

    typedef logic [14:0] sbi_period_t;

endpackage

// *** rtl/sbi_baud_if.sv ***
// Connection between the transmitter sequencer and its bit-rate generator
`timescale 1ns/1ps
interface sbi_baud_if;
    import sbi_pkg::*;

    logic        ce;
    logic        restart;
    logic [7:0]  divisor;
    logic        tick;
    sbi_period_t period;

    modport gen  (input ce, input restart, input divisor, output tick, output period);
    modport user (output ce, output restart, output divisor, input tick, input period);
endinterface

// *** rtl/sbi_baud_gen.sv ***
// Bit-rate generator: one tick per transmitted bit period
`timescale 1ns/1ps
`include "sbi_regs.svh"
module sbi_baud_gen
    import sbi_pkg::*;
#(
    parameter int CORE_DIV = `SBI_CORE_DIV
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    sbi_baud_if.gen   bif
);

    logic [3:0]  prescale;
    logic [7:0]  range;
    logic [11:0] prod;
    logic [7:0]  core_cnt;
    sbi_period_t bit_cnt;
    logic        tick;

    if (CORE_DIV < 1 || CORE_DIV > 256) begin : g_bad_core_div
        $error("CORE_DIV out of range 1..256");
    end

    // ****************************************************************
    // Divisor decode: core ticks per bit = 16 * prescale * range
    // ****************************************************************
    always_comb begin
        unique case (bif.divisor[7:6])
            2'h0: prescale = 4'h1;
            2'h1: prescale = 4'h3;
            2'h2: prescale = 4'h4;
            2'h3: prescale = 4'hD;
        endcase
        range = 8'h01 << bif.divisor[5:3];
        prod  = 12'(prescale * range);
    end

    assign bif.period = {prod[10:0], 4'h0};
    assign bif.tick   = tick;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_cnt <= 8'h00;
            bit_cnt  <= 15'h0000;
            tick     <= 1'b0;
        end else if (bif.ce) begin
            if (bif.restart) begin
                // Load as if one cycle has passed, so the registered tick lands one bit after restart
                core_cnt <= (CORE_DIV == 1) ? 8'h00 : 8'h01;
                bit_cnt  <= (CORE_DIV == 1) ? 15'h0001 : 15'h0000;
                tick     <= 1'b0;
            end else begin
                tick <= 1'b0;
                if (core_cnt == 8'(CORE_DIV - 1)) begin
                    core_cnt <= 8'h00;
                    if (bit_cnt >= bif.period - 15'h0001) begin
                        bit_cnt <= 15'h0000;
                        tick    <= 1'b1;
                    end else begin
                        bit_cnt <= bit_cnt + 15'h0001;
                    end
                end else begin
                    core_cnt <= core_cnt + 8'h01;
                end
            end
        end
    end

endmodule // sbi_baud_gen

// *** rtl/sbi_tx.sv ***
// Serial transmitter with break and idle-line sequencing
//
// How it works
// - Set-then-clear break request sends one break
// - Break lasts 10 or 11 bits, never doubled
// - Breaks repeat while request held, none after
// - Enable re-set queues one idle character first
// - Idle then break: break keeps correct length
// - Divisor C9 at 8 MHz gives 19200 baud
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`include "sbi_regs.svh"
module sbi_tx
    import sbi_pkg::*;
#(
    parameter int CORE_DIV = `SBI_CORE_DIV
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic            tx_data_out
);

    sbi_baud_if bif ();

    logic        send_break_request;
    logic        tx_enable;
    logic        word_length;
    logic        tx_bit8;
    logic [7:0]  baud_divisor_register;
    logic [7:0]  data_hold;
    logic        data_full;
    logic        break_pending;
    logic        idle_pending;
    sbi_state_t  state;
    sbi_state_t  next_state;
    logic        start;
    logic [3:0]  bit_cnt;
    logic [3:0]  frame_bits;
    logic [10:0] shift;
    logic        char_end;
    logic        wr_ctrl;
    logic [27:0] low_run;
    logic [27:0] break_cycles;
    logic [27:0] brk_run;

    if (CORE_DIV < 1 || CORE_DIV > 256) begin : g_bad_core_div
        $error("CORE_DIV out of range 1..256");
    end

    sbi_baud_gen #(
        .CORE_DIV (CORE_DIV)
    ) u_baud (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .bif     (bif.gen)
    );

    assign bif.ce      = clk_en;
    assign bif.restart = start;
    assign bif.divisor = baud_divisor_register;
    assign wr_ctrl     = reg_write && (reg_addr == `SBI_ADDR_CTRL);
    assign frame_bits  = word_length ? `SBI_BITS_LONG : `SBI_BITS_SHORT;

    // ****************************************************************
    // Control and baud registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            send_break_request    <= 1'(`SBI_CTRL_RESET >> `SBI_CTRL_BRK_REQ);
            tx_enable             <= 1'b0;
            word_length           <= 1'b0;
            tx_bit8               <= 1'b0;
            baud_divisor_register <= `SBI_BAUD_RESET;
        end else if (clk_en && reg_write) begin
            if (reg_addr == `SBI_ADDR_CTRL) begin
                send_break_request <= reg_wdata[`SBI_CTRL_BRK_REQ];
                tx_enable          <= reg_wdata[`SBI_CTRL_TX_EN];
                word_length        <= reg_wdata[`SBI_CTRL_M];
                tx_bit8            <= reg_wdata[`SBI_CTRL_T8];
            end
            if (reg_addr == `SBI_ADDR_BAUD) begin
                baud_divisor_register <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // Pending requests; a new request wins over the clear by a start
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            break_pending <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl && reg_wdata[`SBI_CTRL_BRK_REQ] && !send_break_request) begin
                break_pending <= 1'b1;
            end else if (start && next_state == SBI_ST_BREAK) begin
                break_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_pending <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl && reg_wdata[`SBI_CTRL_TX_EN] && !tx_enable) begin
                idle_pending <= 1'b1;
            end else if (start && next_state == SBI_ST_PREAMBLE) begin
                idle_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_hold <= 8'h00;
            data_full <= 1'b0;
        end else if (clk_en) begin
            if (reg_write && reg_addr == `SBI_ADDR_DATA) begin
                data_hold <= reg_wdata;
                data_full <= 1'b1;
            end else if (start && next_state == SBI_ST_DATA) begin
                data_full <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        char_end   = bif.tick && (bit_cnt == frame_bits - 4'h1);
        next_state = state;
        start      = 1'b0;
        unique case (state)
            SBI_ST_BREAK: begin
                if (char_end) begin
                    next_state = SBI_ST_GAP;
                    start      = 1'b1;
                end
            end
            SBI_ST_IDLE, SBI_ST_PREAMBLE, SBI_ST_GAP, SBI_ST_DATA: begin
                if (state == SBI_ST_IDLE || (state == SBI_ST_GAP && bif.tick) ||
                    (state != SBI_ST_GAP && char_end)) begin
                    next_state = SBI_ST_IDLE;
                    if (tx_enable && idle_pending) begin
                        next_state = SBI_ST_PREAMBLE;
                    end else if (tx_enable && (break_pending || send_break_request)) begin
                        next_state = SBI_ST_BREAK;
                    end else if (tx_enable && data_full) begin
                        next_state = SBI_ST_DATA;
                    end
                    start = (next_state != SBI_ST_IDLE);
                end
            end
            default: begin
                next_state = SBI_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SBI_ST_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Bit counter restarts with the rate generator, so every character is whole bits
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt <= 4'h0;
        end else if (clk_en) begin
            if (start) begin
                bit_cnt <= 4'h0;
            end else if (bif.tick) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift <= 11'h7FF;
        end else if (clk_en) begin
            if (start && next_state == SBI_ST_DATA) begin
                shift <= word_length ? {1'b1, tx_bit8, data_hold, 1'b0} : {2'h3, data_hold, 1'b0};
            end else if (bif.tick) begin
                shift <= {1'b1, shift[10:1]};
            end
        end
    end

    // ****************************************************************
    // Line driver
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_data_out <= 1'b1;
        end else if (clk_en) begin
            unique case (state)
                SBI_ST_BREAK: tx_data_out <= 1'b0;
                SBI_ST_DATA:  tx_data_out <= shift[0];
                SBI_ST_IDLE, SBI_ST_PREAMBLE, SBI_ST_GAP: tx_data_out <= 1'b1;
                default:      tx_data_out <= 1'b1;
            endcase
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_read) begin
                unique case (reg_addr)
                    `SBI_ADDR_CTRL: reg_rdata <= {4'h0, tx_bit8, word_length, tx_enable, send_break_request};
                    `SBI_ADDR_BAUD: reg_rdata <= baud_divisor_register;
                    `SBI_ADDR_STAT: reg_rdata <= {2'h0, state == SBI_ST_BREAK, tx_data_out, idle_pending,
                                                  break_pending, !data_full, state != SBI_ST_IDLE};
                    default:        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    assign break_cycles = 28'(frame_bits * CORE_DIV * bif.period);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_run <= 28'h0000000;
        end else if (clk_en) begin
            low_run <= tx_data_out ? 28'h0000000 : low_run + 28'h0000001;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            brk_run <= 28'h0000000;
        end else if (clk_en) begin
            brk_run <= (state == SBI_ST_BREAK) ? brk_run + 28'h0000001 : 28'h0000000;
        end
    end

    a_break_set_pend: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && wr_ctrl && reg_wdata[`SBI_CTRL_BRK_REQ] && !send_break_request)
        |=> (break_pending || state == SBI_ST_BREAK))
        else $error("break request was not registered");

    a_break_low_max: assert property (@(posedge ref_clk) disable iff (!reset_n)
        low_run <= break_cycles)
        else $error("line held low longer than one break character");

    a_no_extra_break: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && state != SBI_ST_BREAK && next_state == SBI_ST_BREAK)
        |-> (break_pending || send_break_request))
        else $error("break started without a request");

    a_idle_queued: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && wr_ctrl && reg_wdata[`SBI_CTRL_TX_EN] && !tx_enable)
        |=> (idle_pending || state == SBI_ST_PREAMBLE))
        else $error("enable re-set did not queue an idle character");

    a_idle_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && state == SBI_ST_IDLE && tx_enable && idle_pending)
        |=> (state == SBI_ST_PREAMBLE))
        else $error("idle character not sent first");

    a_test_rate: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (baud_divisor_register == `SBI_TEST_DIVISOR) |-> (bif.period == `SBI_TEST_PERIOD))
        else $error("test divisor gives wrong bit period");

    a_break_line_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && state == SBI_ST_BREAK) |=> !tx_data_out)
        else $error("line not low during break");

    a_gap_line_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && $past(state) == SBI_ST_BREAK && state == SBI_ST_GAP) |=> (tx_data_out && state == SBI_ST_GAP))
        else $error("no high bit after break");

    a_break_exact: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && state == SBI_ST_BREAK && next_state != SBI_ST_BREAK)
        |-> (brk_run == break_cycles - 28'h0000001))
        else $error("break character has the wrong length");

    a_idle_while_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && !tx_enable && state == SBI_ST_IDLE) |=> (state == SBI_ST_IDLE))
        else $error("transmitter left idle while disabled");

    a_rdata_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && !reg_read) |=> (reg_rdata == 8'h00))
        else $error("read data not zero outside a read answer");

endmodule // sbi_tx

// *** dv/sbi_line_peer.sv ***
// Far-end model of the serial line: measures break and idle runs on the transmit wire
`timescale 1ns/1ps
module sbi_line_peer (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        line,
    output logic      [15:0] brk_count,
    output logic      [31:0] low_len,
    output logic      [31:0] high_len,
    output logic      [31:0] fall_cyc,
    output logic      [31:0] cyc
);
    // ****************************************************************
    // Run-length measurement
    // ****************************************************************
    logic [31:0] run;
    logic        last;

    // Every low run is counted; the only data character queued is all ones
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            brk_count <= 16'h0;
            low_len   <= 32'h0;
            high_len  <= 32'h0;
            fall_cyc  <= 32'h0;
            cyc       <= 32'h0;
            run       <= 32'h0;
            last      <= 1'b1;
        end else begin
            cyc  <= cyc + 32'h1;
            last <= line;
            if (line === last) begin
                run <= run + 32'h1;
            end else begin
                run <= 32'h1;
                if (line) begin
                    low_len   <= run;
                    brk_count <= brk_count + 16'h1;
                end else begin
                    high_len <= run;
                    fall_cyc <= cyc;
                end
            end
        end
    end
endmodule // sbi_line_peer

// *** dv/tb_serial_break_idle_transmit.sv ***
// Self-checking bench for the break and idle-line transmitter
`timescale 1ns/1ps
`include "sbi_regs.svh"
module tb_serial_break_idle_transmit;
    localparam int CORE_DIV = 1;

    logic        ref_clk;
    logic        reset_n;
    logic        clk_en;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_rdata;
    logic        tx_data_out;
    logic [15:0] brk_count;
    logic [31:0] low_len;
    logic [31:0] high_len;
    logic [31:0] fall_cyc;
    logic [31:0] cyc;
    logic [31:0] t0;
    logic [7:0]  rd;
    logic [7:0]  rnd;
    int          num_errors;
    int          checked;
    int          seed;
    logic [7:0]  baud_tab [4] = '{8'h00, 8'h08, 8'h40, 8'h48};

    sbi_tx #(.CORE_DIV(CORE_DIV)) sbi_tx_i (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_write  (reg_write),
        .reg_read   (reg_read),
        .reg_rdata  (reg_rdata),
        .tx_data_out(tx_data_out)
    );

    sbi_line_peer sbi_line_peer_i (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .line     (tx_data_out),
        .brk_count(brk_count),
        .low_len  (low_len),
        .high_len (high_len),
        .fall_cyc (fall_cyc),
        .cyc      (cyc)
    );

    // ****************************************************************
    // Expectations
    // ****************************************************************
    function automatic logic [31:0] bit_cycles(input logic [7:0] b);
        logic [31:0] p;
        case (b[7:6])
            2'h0: p = 32'h1;
            2'h1: p = 32'h3;
            2'h2: p = 32'h4;
            default: p = 32'hD;
        endcase
        return CORE_DIV * 16 * p * (32'h1 << b[5:3]);
    endfunction

    function automatic logic [31:0] frame_cycles(input logic [7:0] b, input logic ml);
        return (ml ? 32'hB : 32'hA) * bit_cycles(b);
    endfunction

    // ****************************************************************
    // Checks and bus tasks
    // ****************************************************************
    task automatic check_in(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("ERROR %s expected %0h..%0h seen %0h", what, lo, hi, got);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_brk(input logic [15:0] n, input int limit);
        for (int i = 0; i < limit && brk_count < n; i++) @(posedge ref_clk);
        #1;
        check_in("break count", {16'h0, n}, {16'h0, n}, {16'h0, brk_count});
    endtask

    // One break request, optionally preceded by an idle request
    task automatic one_break(input logic [7:0] b, input logic ml, input logic idle);
        logic [15:0] n0;
        logic [31:0] fr;
        n0 = brk_count;
        fr = frame_cycles(b, ml);
        reg_wr(`SBI_ADDR_BAUD, b);
        reg_wr(`SBI_ADDR_CTRL, {5'h0, ml, ~idle, 1'b0});
        if (idle) reg_wr(`SBI_ADDR_CTRL, {5'h0, ml, 2'h2});
        t0 = cyc;
        reg_wr(`SBI_ADDR_CTRL, {5'h0, ml, 2'h3});
        if (!idle) t0 = cyc;
        reg_wr(`SBI_ADDR_CTRL, {5'h0, ml, 2'h2});
        if (!idle) begin
            reg_rd(`SBI_ADDR_STAT, rd);
            check_in("status in break", 32'h20, 32'h20, {24'h0, rd & 8'h30});
        end
        wait_brk(n0 + 16'h1, 3 * fr + 64);
        check_in("break length", fr, fr, low_len);
        if (idle) check_in("idle before break", fr, fr + 8, fall_cyc - t0);
        else check_in("break latency", 32'h1, 32'h4, fall_cyc - t0);
        repeat (2 * fr) @(posedge ref_clk);
        check_in("no extra break", {16'h0, n0} + 1, {16'h0, n0} + 1, {16'h0, brk_count});
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************************************************************
    // Clock and watchdog
    // ****************************************************************
    always #2.5 ref_clk = ~ref_clk;

    initial begin
        repeat (90000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        ref_clk    = 1'b0;
        reset_n    = 1'b0;
        clk_en     = 1'b1;
        reg_addr   = 3'h0;
        reg_wdata  = 8'h00;
        reg_write  = 1'b0;
        reg_read   = 1'b0;
        num_errors = 0;
        checked    = 0;
        seed       = 6;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_rd(`SBI_ADDR_CTRL, rd);
        check_in("control reset", 32'h0, 32'h0, {24'h0, rd});
        reg_rd(`SBI_ADDR_BAUD, rd);
        check_in("divisor reset", 32'h0, 32'h0, {24'h0, rd});
        reg_wr(3'h6, 8'hA5);
        reg_rd(3'h6, rd);
        check_in("unmapped read", 32'h0, 32'h0, {24'h0, rd});
        rnd = 8'($random(seed));
        reg_wr(`SBI_ADDR_BAUD, rnd);
        reg_rd(`SBI_ADDR_BAUD, rd);
        check_in("divisor readback", {24'h0, rnd}, {24'h0, rnd}, {24'h0, rd});
        // Break requested while the transmitter is off stays pending
        reg_wr(`SBI_ADDR_CTRL, 8'h01);
        reg_wr(`SBI_ADDR_CTRL, 8'h00);
        repeat (64) @(posedge ref_clk);
        check_in("line while disabled", 32'h1, 32'h1, {31'h0, tx_data_out});
        check_in("no break while disabled", 32'h0, 32'h0, {16'h0, brk_count});
        one_break(8'h00, 1'b0, 1'b1);
        one_break(8'h00, 1'b1, 1'b0);
        for (int k = 0; k < 6; k++) begin
            rnd = 8'($random(seed));
            one_break(baud_tab[rnd[1:0]], rnd[2], rnd[3]);
        end
        one_break(`SBI_TEST_DIVISOR, 1'b0, 1'b0);
        // Held request repeats breaks, each followed by one high gap bit
        reg_wr(`SBI_ADDR_BAUD, 8'h00);
        reg_wr(`SBI_ADDR_CTRL, 8'h02);
        t0 = {16'h0, brk_count};
        reg_wr(`SBI_ADDR_CTRL, 8'h03);
        wait_brk(t0[15:0] + 16'h3, 600);
        reg_wr(`SBI_ADDR_CTRL, 8'h02);
        check_in("break length", 32'hA0, 32'hA0, low_len);
        check_in("gap between breaks", 32'h10, 32'h12, high_len);
        repeat (600) @(posedge ref_clk);
        check_in("breaks after clear", t0 + 3, t0 + 3, {16'h0, brk_count});
        // Frozen clock-enable cycles stretch a break by exactly their number
        t0 = {16'h0, brk_count};
        reg_wr(`SBI_ADDR_CTRL, 8'h03);
        reg_wr(`SBI_ADDR_CTRL, 8'h02);
        repeat (20) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (7) @(posedge ref_clk);
        clk_en <= 1'b1;
        wait_brk(t0[15:0] + 16'h1, 600);
        check_in("frozen break length", 32'hA7, 32'hA7, low_len);
        // A queued all-ones data character shows one low start bit of one bit period
        reg_wr(`SBI_ADDR_DATA, 8'hFF);
        wait_brk(t0[15:0] + 16'h2, 600);
        check_in("start bit length", 32'h10, 32'h10, low_len);
        print_verdict();
    end
endmodule // tb_serial_break_idle_transmit
